// ==== common/fcvoc_pkg.sv ====
/*
  Constants, record layout and range decoding for the four channel
  voltage output control block.
  Assumes a 10 MHz module clock and byte-wide record access.
*/
// Contract
// - Green status steady when bus and module OK
// - Red status steady while module reports error
// - Red status blinks 1 Hz on configuration error
// - Green status blinks 1 Hz on bus fault
// - No input image bytes are supplied
// - Output byte zero bits map channels 0-3
// - Parameter record six bytes, ranges 80h-83h
// - Short enable bits 0-3 per channel, default 0
// - Range code FFh deactivates the channel
// - Code 12h: 27648 is 10 V, limits 32511/-32512
// - Code 22h: 16384 is 10 V, limits +/-20480
// - Unipolar 10h/20h clamp negatives to zero
// - Errors light channel LED, record diagnostic
// - Parameter errors appear in diagnostic data
// - Short reported only when detection enabled
// - Record 01h full diagnostic, 00h first four
// - Fixed descriptor bytes 15h 73h 08h 04h
// - Module diagnostic byte bits 0-4 and 7
// - Channel byte bit0 parameter, bit3 short
// - Channel summary bits 0-3 per channel
// - 32-bit microsecond ticker captured on diagnostic
// - Internal byte bit3 overflow, bit4 communication
package fcvoc_pkg;

  // Clock and timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int BLINK_HZ        = 1;
  localparam int BLINK_HALF_CYC  = CLK_HZ / (2 * BLINK_HZ);
  localparam int US_NS           = 1000;
  localparam int CLK_NS          = 1_000_000_000 / CLK_HZ;
  localparam int US_CYC          = US_NS / CLK_NS;

  // Record numbers
  localparam logic [7:0] REC_DIAG_SHORT = 8'h00;
  localparam logic [7:0] REC_DIAG_FULL  = 8'h01;
  localparam logic [7:0] REC_PARAM      = 8'h00;
  localparam logic [7:0] REC_RANGE_CH0  = 8'h80;
  localparam int         PARAM_BYTES    = 6;
  localparam int         DIAG_BYTES     = 20;
  localparam int         DIAG_SHORT_LEN = 4;

  // Parameter record byte positions
  localparam int PARAM_RSVD_IDX  = 0;
  localparam int PARAM_SHORT_IDX = 1;
  localparam int PARAM_RANGE_IDX = 2;

  // Reset values
  localparam logic [7:0] SHORT_DET_RST = 8'h00;
  localparam logic [7:0] RANGE_RST     = 8'h12;

  // Range codes
  localparam logic [7:0] RANGE_BI_K27  = 8'h12;
  localparam logic [7:0] RANGE_BI_K16  = 8'h22;
  localparam logic [7:0] RANGE_UNI_K27 = 8'h10;
  localparam logic [7:0] RANGE_UNI_K16 = 8'h20;
  localparam logic [7:0] RANGE_OFF     = 8'hFF;

  // Saturation limits
  localparam logic signed [15:0] K27_MAX = 16'sh7EFF;
  localparam logic signed [15:0] K27_MIN = 16'sh8100;
  localparam logic signed [15:0] K16_MAX = 16'sh5000;
  localparam logic signed [15:0] K16_MIN = 16'shB000;
  localparam logic signed [15:0] ZERO_W  = 16'sh0000;

  // Diagnostic descriptor bytes
  localparam logic [7:0] MOD_CLASS_INFO = 8'h15;
  localparam logic [7:0] CHAN_KIND      = 8'h73;
  localparam logic [7:0] DIAG_BITS_CH   = 8'h08;
  localparam logic [7:0] CHAN_COUNT     = 8'h04;

  // Module diagnostic byte fields
  localparam int MFS_FAIL   = 0;
  localparam int MFS_INT    = 1;
  localparam int MFS_EXT    = 2;
  localparam int MFS_CHAN   = 3;
  localparam int MFS_AUX    = 4;
  localparam int MFS_PARAM  = 7;
  // Internal diagnostic byte fields
  localparam int IFB_OVF    = 3;
  localparam int IFB_COMM   = 4;
  // Channel detail byte fields
  localparam int CHD_PARAM  = 0;
  localparam int CHD_SHORT  = 3;

  // True when the range code is one the converter supports
  function automatic logic fcvoc_range_ok(input logic [7:0] code);
    fcvoc_range_ok = (code == RANGE_BI_K27) || (code == RANGE_BI_K16)
                  || (code == RANGE_UNI_K27) || (code == RANGE_UNI_K16);
  endfunction : fcvoc_range_ok

endpackage : fcvoc_pkg

// ==== hdl/fcvoc_chan.sv ====
/*
  One output channel: decodes its range code into scale and limits
  and saturates the output word for the converter.
  Assumes range code and word are held stable by the parent.
*/
`timescale 1ns/1ps
module fcvoc_chan
  import fcvoc_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic [7:0]         range_code,
  input  wire logic               release_out,
  input  wire logic signed [15:0] word,
  output logic signed [15:0]      dac_word,
  output logic                    scale_k16,
  output logic                    active,
  output logic                    param_err
);

  logic signed [15:0] hi;
  logic signed [15:0] lo;
  logic               ok;
  logic               narrow;

  // Limits per range; unipolar floors at zero
  always_comb
  begin
    ok     = fcvoc_range_ok(range_code);
    narrow = (range_code == RANGE_BI_K16) || (range_code == RANGE_UNI_K16);
    hi     = narrow ? K16_MAX : K27_MAX;
    unique case (range_code)
      RANGE_BI_K16:  lo = K16_MIN;
      RANGE_UNI_K27: lo = ZERO_W;
      RANGE_UNI_K16: lo = ZERO_W;
      default:       lo = K27_MIN;
    endcase
  end

  // Saturated converter word, zero when channel is off
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      dac_word <= ZERO_W;
      scale_k16 <= 1'b0;
      active   <= 1'b0;
    end
    else
    begin
      active   <= ok && release_out;
      scale_k16 <= narrow;
      if (!(ok && release_out))
        dac_word <= ZERO_W;
      else if (word > hi)
        dac_word <= hi;
      else if (word < lo)
        dac_word <= lo;
      else
        dac_word <= word;
    end
  end

  // Unsupported code, deactivate value excepted
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      param_err <= 1'b0;
    else
      param_err <= !ok && (range_code != RANGE_OFF);
  end

endmodule : fcvoc_chan

// ==== hdl/fcvoc_top.sv ====
/*
  Four channel voltage output control: parameter and diagnostic
  records, output image, channel scaling, status and channel LEDs.
  Assumes record and image strobes are one-cycle pulses synchronous
  to clk; fault inputs are synchronous levels. No input image exists.
*/
`timescale 1ns/1ps
module fcvoc_top
  import fcvoc_pkg::*;
#(
  parameter int BLINK_HALF = fcvoc_pkg::BLINK_HALF_CYC
)
(
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               rec_wr,
  input  wire logic               rec_rd,
  input  wire logic [7:0]         rec_id,
  input  wire logic [7:0]         rec_index,
  input  wire logic [7:0]         rec_wdata,
  output logic [7:0]              rec_rdata,
  output logic                    rec_rvalid,
  output logic                    rec_rerr,
  input  wire logic               ctrl_wr,
  input  wire logic [7:0]         ctrl_byte,
  input  wire logic               word_wr,
  input  wire logic [1:0]         word_ch,
  input  wire logic signed [15:0] word_data,
  input  wire logic               bus_fault,
  input  wire logic               aux_supply_ok,
  input  wire logic [3:0]         short_detect,
  input  wire logic               diag_buf_overflow,
  input  wire logic               internal_comm_error,
  output logic signed [15:0]      voltage_out_ch0,
  output logic signed [15:0]      voltage_out_ch1,
  output logic signed [15:0]      voltage_out_ch2,
  output logic signed [15:0]      voltage_out_ch3,
  output logic [3:0]              scale_k16,
  output logic [3:0]              channel_active,
  output logic                    green_led,
  output logic                    red_led,
  output logic [3:0]              channel_led
);

  import fcvoc_pkg::*;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0]         output_channel_byte;
  logic [3:0]         short_detect_enable;
  logic [7:0]         range_code [4];
  logic signed [15:0] out_word [4];
  logic signed [15:0] dac_word [4];
  logic [3:0]         param_err;
  logic [7:0]         ch_fault_detail [4];
  logic [7:0]         channel_fault_summary;
  logic [7:0]         module_fault_summary;
  logic [7:0]         internal_fault_byte;
  logic [31:0]        us_count;
  logic [31:0]        fault_timestamp_us;
  logic [7:0]         us_div;
  logic [31:0]        blink_cnt;
  logic               blink;
  logic [31:0]        last_fault;
  logic [31:0]        next_fault;
  logic [7:0]         diag_byte;
  logic [7:0]         param_byte;

  // ------------------------------------------------------------
  // Output image
  // ------------------------------------------------------------

  // Byte zero of the image releases channels 0-3
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      output_channel_byte <= 8'h00;
    else if (ctrl_wr)
      output_channel_byte <= ctrl_byte;
  end

  // Channel output words
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < 4; i++)
        out_word[i] <= ZERO_W;
    end
    else if (word_wr)
      out_word[word_ch] <= word_data;
  end

  // ------------------------------------------------------------
  // Parameter record
  // ------------------------------------------------------------

  // Record 00h bytes and range records 80h-83h
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      short_detect_enable <= SHORT_DET_RST[3:0];
      for (int i = 0; i < 4; i++)
        range_code[i] <= RANGE_RST;
    end
    else if (rec_wr)
    begin
      if (rec_id == REC_PARAM)
      begin
        if (rec_index == 8'(PARAM_SHORT_IDX))
          short_detect_enable <= rec_wdata[3:0];
        else if (rec_index >= 8'(PARAM_RANGE_IDX)
                 && rec_index < 8'(PARAM_BYTES))
          range_code[2'(rec_index - 8'(PARAM_RANGE_IDX))] <= rec_wdata;
      end
      else if (rec_id[7:2] == REC_RANGE_CH0[7:2] && rec_index == 8'h00)
        range_code[rec_id[1:0]] <= rec_wdata;
    end
  end

  // ------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------

  // One scaler per channel
  generate
    for (genvar g = 0; g < 4; g++)
    begin : g_chan
      fcvoc_chan u_chan
      (
        .clk         (clk),
        .reset       (reset),
        .range_code  (range_code[g]),
        .release_out (output_channel_byte[g]),
        .word        (out_word[g]),
        .dac_word    (dac_word[g]),
        .scale_k16   (scale_k16[g]),
        .active      (channel_active[g]),
        .param_err   (param_err[g])
      );
    end
  endgenerate

  assign voltage_out_ch0 = dac_word[0];
  assign voltage_out_ch1 = dac_word[1];
  assign voltage_out_ch2 = dac_word[2];
  assign voltage_out_ch3 = dac_word[3];

  // ------------------------------------------------------------
  // Diagnostic bytes
  // ------------------------------------------------------------

  // Per-channel detail, short gated by its enable
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < 4; i++)
        ch_fault_detail[i] <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        ch_fault_detail[i]            <= 8'h00;
        ch_fault_detail[i][CHD_PARAM] <= param_err[i];
        ch_fault_detail[i][CHD_SHORT] <= short_detect[i]
                                         && short_detect_enable[i];
      end
    end
  end

  // Channel summary and internal bytes
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      channel_fault_summary <= 8'h00;
      internal_fault_byte   <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
        channel_fault_summary[i] <= |ch_fault_detail[i];
      channel_fault_summary[7:4] <= 4'h0;
      internal_fault_byte             <= 8'h00;
      internal_fault_byte[IFB_OVF]  <= diag_buf_overflow;
      internal_fault_byte[IFB_COMM] <= internal_comm_error;
    end
  end

  // Module diagnostic byte assembled from the other bytes and the fault inputs
  always_comb
  begin
    module_fault_summary            = 8'h00;
    module_fault_summary[MFS_INT]   = |internal_fault_byte;
    module_fault_summary[MFS_EXT]   = |(short_detect & short_detect_enable);
    module_fault_summary[MFS_CHAN]  = |channel_fault_summary;
    module_fault_summary[MFS_AUX]   = !aux_supply_ok;
    module_fault_summary[MFS_PARAM] = |param_err;
    module_fault_summary[MFS_FAIL]  = |module_fault_summary;
  end

  // ------------------------------------------------------------
  // Microsecond ticker and capture
  // ------------------------------------------------------------

  // Free-running ticker from reset, wraps at 2^32
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      us_div   <= 8'h00;
      us_count <= 32'h0000_0000;
    end
    else if (us_div == 8'(US_CYC - 1))
    begin
      us_div   <= 8'h00;
      us_count <= us_count + 32'h0000_0001;
    end
    else
      us_div <= us_div + 8'h01;
  end

  // Fault picture whose change marks a new diagnostic
  assign next_fault = {module_fault_summary, channel_fault_summary,
                       internal_fault_byte, 4'h0, param_err};

  // Timestamp latched when a nonzero diagnostic appears or changes
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      last_fault         <= 32'h0000_0000;
      fault_timestamp_us <= 32'h0000_0000;
    end
    else
    begin
      last_fault <= next_fault;
      if (next_fault != last_fault && next_fault != 32'h0000_0000)
        fault_timestamp_us <= us_count;
    end
  end

  // ------------------------------------------------------------
  // Record read-back
  // ------------------------------------------------------------

  // Diagnostic record byte by index
  always_comb
  begin
    unique case (rec_index)
      8'd0:    diag_byte = module_fault_summary;
      8'd1:    diag_byte = MOD_CLASS_INFO;
      8'd2:    diag_byte = 8'h00;
      8'd3:    diag_byte = internal_fault_byte;
      8'd4:    diag_byte = CHAN_KIND;
      8'd5:    diag_byte = DIAG_BITS_CH;
      8'd6:    diag_byte = CHAN_COUNT;
      8'd7:    diag_byte = channel_fault_summary;
      8'd8:    diag_byte = ch_fault_detail[0];
      8'd9:    diag_byte = ch_fault_detail[1];
      8'd10:   diag_byte = ch_fault_detail[2];
      8'd11:   diag_byte = ch_fault_detail[3];
      8'd16:   diag_byte = fault_timestamp_us[7:0];
      8'd17:   diag_byte = fault_timestamp_us[15:8];
      8'd18:   diag_byte = fault_timestamp_us[23:16];
      8'd19:   diag_byte = fault_timestamp_us[31:24];
      default: diag_byte = 8'h00;                   // Spare channel bytes
    endcase
  end

  // Range code read from a range record
  assign param_byte = range_code[rec_id[1:0]];

  // Registered answer one cycle after the read strobe
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rec_rdata  <= 8'h00;
      rec_rvalid <= 1'b0;
      rec_rerr   <= 1'b0;
    end
    else
    begin
      rec_rvalid <= 1'b0;
      rec_rerr   <= 1'b0;
      if (rec_rd)
      begin
        if (rec_id == REC_DIAG_FULL && rec_index < 8'(DIAG_BYTES))
        begin
          rec_rdata  <= diag_byte;
          rec_rvalid <= 1'b1;
        end
        else if (rec_id == REC_DIAG_SHORT
                 && rec_index < 8'(DIAG_SHORT_LEN))
        begin
          rec_rdata  <= diag_byte;
          rec_rvalid <= 1'b1;
        end
        else if (rec_id[7:2] == REC_RANGE_CH0[7:2] && rec_index == 8'h00)
        begin
          rec_rdata  <= param_byte;
          rec_rvalid <= 1'b1;
        end
        else
        begin
          rec_rdata <= 8'h00;
          rec_rerr  <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // LEDs
  // ------------------------------------------------------------

  // 1 Hz blink source
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      blink_cnt <= 32'h0000_0000;
      blink     <= 1'b0;
    end
    else if (blink_cnt >= 32'(BLINK_HALF - 1))
    begin
      blink_cnt <= 32'h0000_0000;
      blink     <= ~blink;
    end
    else
      blink_cnt <= blink_cnt + 32'h0000_0001;
  end

  // Status and channel LEDs
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      green_led   <= 1'b0;
      red_led     <= 1'b0;
      channel_led <= 4'h0;
    end
    else
    begin
      if (bus_fault)
        green_led <= blink;
      else
        green_led <= (module_fault_summary == 8'h00);
      if (|param_err)
        red_led <= blink;
      else
        red_led <= (module_fault_summary != 8'h00);
      for (int i = 0; i < 4; i++)
        channel_led[i] <= |ch_fault_detail[i];
    end
  end

  // No input image: nothing is returned cyclically to the host

endmodule : fcvoc_top

// ==== tb/fcvoc_host.sv ====
/*
  Host side of the record channel: writes and reads single record bytes.
  Assumes a free running clk; strobes change only just after a rising edge.
*/
`timescale 1ns/1ps
module fcvoc_host
(
  input  wire logic  clk,
  output logic       rec_wr,
  output logic       rec_rd,
  output logic [7:0] rec_id,
  output logic [7:0] rec_index,
  output logic [7:0] rec_wdata
);
  // Idle values at time zero
  initial
  begin
    rec_wr    = 1'b0;
    rec_rd    = 1'b0;
    rec_id    = 8'hFF;
    rec_index = 8'hFF;
    rec_wdata = 8'h00;
  end

  // One parameter byte per strobe, held for exactly one taking edge
  task automatic wr(input logic [7:0] id, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    rec_wr    <= 1'b1;
    rec_id    <= id;
    rec_index <= idx;
    rec_wdata <= d;
    @(posedge clk);
    rec_wr    <= 1'b0;
    rec_id    <= ~id; // Released lines no longer show the last value
    rec_index <= ~idx;
    rec_wdata <= ~d;
  endtask : wr

  // Record byte request (diagnostic or range record); the answer comes one edge later
  task automatic rd(input logic [7:0] id, input logic [7:0] idx);
    @(posedge clk);
    rec_rd    <= 1'b1;
    rec_id    <= id;
    rec_index <= idx;
    @(posedge clk);
    rec_rd    <= 1'b0;
    rec_id    <= ~id;
    rec_index <= ~idx;
  endtask : rd
endmodule : fcvoc_host

// ==== tb/fcvoc_chk.sv ====
/*
  Concurrent checks on the ports of fcvoc_top.
  Assumes BLINK_HALF matches the bound instance.
*/
`timescale 1ns/1ps
module fcvoc_chk
#(
  parameter int BLINK_HALF = 4
)
(
  input wire logic               clk,
  input wire logic               reset,
  input wire logic               rec_wr,
  input wire logic               rec_rd,
  input wire logic [7:0]         rec_id,
  input wire logic [7:0]         rec_index,
  input wire logic [7:0]         rec_wdata,
  input wire logic [7:0]         rec_rdata,
  input wire logic               rec_rvalid,
  input wire logic               rec_rerr,
  input wire logic               bus_fault,
  input wire logic signed [15:0] voltage_out_ch0,
  input wire logic signed [15:0] voltage_out_ch1,
  input wire logic [3:0]         scale_k16,
  input wire logic [3:0]         channel_active,
  input wire logic               green_led
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // ----------------------------------------
  // Green hold counter while the bus is faulty
  // ----------------------------------------
  logic        green_q;
  logic [31:0] green_still;

  // Previous green level
  always_ff @(posedge clk or posedge reset)
    if (reset) green_q <= 1'b0;
    else green_q <= green_led;

  // Cycles without a green change during a bus fault
  always_ff @(posedge clk or posedge reset)
    if (reset) green_still <= 32'h0;
    else if (!bus_fault || green_led != green_q) green_still <= 32'h0;
    else green_still <= green_still + 32'h1;

  sequence s_k16_write;
    rec_wr && rec_id == 8'h80 && rec_index == 8'h00 && rec_wdata == 8'h22;
  endsequence
  sequence s_class_read;
    rec_rd && rec_id == 8'h01 && rec_index == 8'h01;
  endsequence

  a_rd_answer: assert property (rec_rd |=> rec_rvalid != rec_rerr)
    else $error("record read not answered once");
  a_rd_quiet: assert property (!rec_rd |=> !rec_rvalid && !rec_rerr)
    else $error("record answer without request");
  a_desc_class: assert property (s_class_read |=> rec_rvalid && rec_rdata == 8'h15)
    else $error("module class byte wrong");
  a_desc_kind: assert property (
    rec_rd && rec_id == 8'h01 && rec_index == 8'h04 |=> rec_rdata == 8'h73)
    else $error("channel kind byte wrong");
  a_short_refuse: assert property (
    rec_rd && rec_id == 8'h00 && rec_index >= 8'h04 |=> rec_rerr && rec_rdata == 8'h00)
    else $error("short record beyond four bytes answered");
  a_k16_scale: assert property (s_k16_write |=> ##1 scale_k16[0])
    else $error("range 22h scale not applied");
  a_out_limit: assert property (voltage_out_ch0 >= -16'sd32512)
    else $error("converter word below widest limit");
  a_off_zero: assert property (!channel_active[1] |-> voltage_out_ch1 == 16'sh0000)
    else $error("inactive channel drives a word");
  a_green_blink: assert property (green_still <= BLINK_HALF + 3)
    else $error("green not blinking on bus fault");
endmodule : fcvoc_chk

bind fcvoc_top fcvoc_chk #(.BLINK_HALF(BLINK_HALF)) u_fcvoc_chk (.clk(clk), .reset(reset),
  .rec_wr(rec_wr), .rec_rd(rec_rd), .rec_id(rec_id), .rec_index(rec_index),
  .rec_wdata(rec_wdata), .rec_rdata(rec_rdata), .rec_rvalid(rec_rvalid),
  .rec_rerr(rec_rerr), .bus_fault(bus_fault), .voltage_out_ch0(voltage_out_ch0),
  .voltage_out_ch1(voltage_out_ch1), .scale_k16(scale_k16),
  .channel_active(channel_active), .green_led(green_led));

// ==== tb/tb_top.sv ====
/*
  Self-checking bench for fcvoc_top: records, scaling, diagnostics, LEDs.
  Assumes the host model fcvoc_host and the bound checker.
*/
`timescale 1ns/1ps
module tb_top;
  import fcvoc_pkg::*;
  logic clk, reset, rec_wr, rec_rd, rec_rvalid, rec_rerr, ctrl_wr, word_wr;
  logic bus_fault, aux_supply_ok, diag_buf_overflow, internal_comm_error;
  logic green_led, red_led;
  logic [7:0] rec_id, rec_index, rec_wdata, rec_rdata, ctrl_byte;
  logic [1:0] word_ch;
  logic [3:0] short_detect, scale_k16, channel_active, channel_led;
  logic signed [15:0] word_data;
  logic signed [15:0] vout [4];
  logic [15:0] exp_q [$];
  logic [7:0] codes [5] = '{8'h12, 8'h22, 8'h10, 8'h20, 8'hFF};
  int errors, compares, seed;

  fcvoc_host u_fcvoc_host (.clk(clk), .rec_wr(rec_wr), .rec_rd(rec_rd), .rec_id(rec_id),
    .rec_index(rec_index), .rec_wdata(rec_wdata));

  fcvoc_top #(.BLINK_HALF(4)) u_fcvoc_top (.clk(clk), .reset(reset), .rec_wr(rec_wr),
    .rec_rd(rec_rd), .rec_id(rec_id), .rec_index(rec_index), .rec_wdata(rec_wdata),
    .rec_rdata(rec_rdata), .rec_rvalid(rec_rvalid), .rec_rerr(rec_rerr),
    .ctrl_wr(ctrl_wr), .ctrl_byte(ctrl_byte), .word_wr(word_wr), .word_ch(word_ch),
    .word_data(word_data), .bus_fault(bus_fault), .aux_supply_ok(aux_supply_ok),
    .short_detect(short_detect), .diag_buf_overflow(diag_buf_overflow),
    .internal_comm_error(internal_comm_error), .voltage_out_ch0(vout[0]),
    .voltage_out_ch1(vout[1]), .voltage_out_ch2(vout[2]), .voltage_out_ch3(vout[3]),
    .scale_k16(scale_k16), .channel_active(channel_active), .green_led(green_led),
    .red_led(red_led), .channel_led(channel_led));

  // 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Verdict and end of run
  task automatic end_of_test;
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // Note the expected answer, then issue the read
  task automatic rd(input logic [7:0] id, input logic [7:0] idx, input logic [8:0] e);
    exp_q.push_back({7'h00, e});
    u_fcvoc_host.rd(id, idx);
  endtask : rd

  // Saturated converter word for a range code
  function automatic logic signed [15:0] exp_out(input logic [7:0] c,
                                                 input logic signed [15:0] w);
    logic signed [15:0] hi, lo;
    hi = (c == 8'h22 || c == 8'h20) ? 16'sh5000 : 16'sh7EFF;
    lo = (c == 8'h12) ? 16'sh8100 : (c == 8'h22) ? 16'shB000 : 16'sh0000;
    return (w > hi) ? hi : (w < lo) ? lo : w;
  endfunction : exp_out

  // Count LED changes over a window
  task automatic toggles(input logic red, output int n);
    logic last;
    n = 0;
    last = red ? red_led : green_led;
    repeat (24)
    begin
      @(negedge clk);
      if ((red ? red_led : green_led) !== last) n++;
      last = red ? red_led : green_led;
    end
  endtask : toggles

  // Answer watcher: oldest note against each answer
  always @(posedge clk)
  begin
    if (rec_rvalid === 1'b1 || rec_rerr === 1'b1)
    begin
      if (exp_q.size() == 0) check(16'hFFFF, 16'h0000, "unexpected answer");
      else check({7'h00, rec_rerr, rec_rdata}, exp_q.pop_front(), "record answer");
    end
  end

  // Main sequence
  initial
  begin
    int n;
    logic [7:0] c, rel;
    logic [1:0] ch;
    logic signed [15:0] w, e;
    seed = 32'h0345FF93;
    {reset, ctrl_wr, word_wr, bus_fault, diag_buf_overflow, internal_comm_error} = 6'h3F;
    {ctrl_wr, word_wr, bus_fault, diag_buf_overflow, internal_comm_error} = 5'h00;
    {ctrl_byte, word_ch, word_data, short_detect} = 30'h0;
    aux_supply_ok = 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(negedge clk);
    check(16'(green_led), 16'h0001, "green steady");
    for (int k = 0; k < 20; k++)
      rd(8'h01, 8'(k), {1'b0, (k == 1) ? 8'h15 : (k == 4) ? 8'h73 : (k == 5) ? 8'h08 :
         (k == 6) ? 8'h04 : 8'h00});
    for (int k = 0; k < 4; k++)
      rd(8'h00, 8'(k), {1'b0, (k == 1) ? 8'h15 : 8'h00});
    for (int k = 0; k < 4; k++)
      rd(8'h80 + 8'(k), 8'h00, 9'h012);
    rd(8'h00, 8'h04, 9'h100);
    rd(8'h01, 8'd20, 9'h100);
    rd(8'h55, 8'h00, 9'h100);
    for (int i = 0; i < 40; i++)
    begin
      c = codes[i % 5];
      ch = 2'($random(seed));
      rel = 8'($random(seed)) | ((i < 10) ? (8'h01 << ch) : 8'h00);
      w = (i < 10) ? (i[0] ? 16'sh8000 : 16'sh7FFF) : 16'($random(seed));
      u_fcvoc_host.wr(8'h80 + 8'(ch), 8'h00, c);
      @(posedge clk);
      ctrl_wr <= 1'b1;
      ctrl_byte <= rel;
      word_wr <= 1'b1;
      word_ch <= ch;
      word_data <= w;
      @(posedge clk);
      ctrl_wr <= 1'b0;
      word_wr <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      e = (rel[ch] && c != 8'hFF) ? exp_out(c, w) : 16'sh0000;
      check(vout[ch], e, "converter word");
      check(16'(channel_active[ch]), 16'(rel[ch] && c != 8'hFF), "active");
      check(16'(scale_k16[ch]), 16'(c == 8'h22 || c == 8'h20), "scale");
    end
    u_fcvoc_host.wr(8'h00, 8'h04, 8'h33);
    repeat (4) @(posedge clk);
    rd(8'h01, 8'd10, 9'h001);
    rd(8'h01, 8'd7, 9'h004);
    rd(8'h01, 8'd0, 9'h089);
    check(16'(channel_led[2]), 16'h0001, "channel led");
    toggles(1'b1, n);
    check(16'(n >= 3), 16'h0001, "red blink");
    u_fcvoc_host.wr(8'h82, 8'h00, 8'h12);
    short_detect <= 4'h1;
    repeat (4) @(posedge clk);
    rd(8'h01, 8'd8, 9'h000);
    u_fcvoc_host.wr(8'h00, 8'h01, 8'h01);
    repeat (4) @(posedge clk);
    rd(8'h01, 8'd8, 9'h008);
    rd(8'h01, 8'd0, 9'h00D);
    check(16'(red_led), 16'h0001, "red steady");
    short_detect <= 4'h0;
    aux_supply_ok <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h01, 8'd0, 9'h011);
    aux_supply_ok <= 1'b1;
    diag_buf_overflow <= 1'b1;
    internal_comm_error <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h01, 8'd3, 9'h018);
    diag_buf_overflow <= 1'b0;
    internal_comm_error <= 1'b0;
    bus_fault <= 1'b1;
    toggles(1'b0, n);
    check(16'(n >= 3), 16'h0001, "green blink");
    bus_fault <= 1'b0;
    u_fcvoc_host.wr(8'h80, 8'h00, 8'h22);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(16'(scale_k16[0]), 16'h0001, "scale ch0");
    n = 0;
    while (exp_q.size() != 0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (exp_q.size() != 0) check(16'hFFFF, 16'h0000, "answer missing");
    end_of_test();
  end
endmodule : tb_top
